// ---- core/lin_input_sync.sv ----
// two-stage synchronisers for asynchronous pin inputs
`timescale 1ns/100ps
module lin_input_sync (
  input wire logic clk_in, // core clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic select_wake_in, // raw select/wake pin
  input wire logic fault_enable_in, // raw fault/enable pin level
  input wire logic tx_data_in, // raw transmit data pin
  input wire logic bus_level_in, // raw bus comparator level
  lin_sync_if.producer sync_out // synchronised levels
);
  logic [3:0] stage1_ff;
  logic [3:0] stage2_ff;

  // ------------------------------------------------------------
  // synchroniser chain
  // ------------------------------------------------------------
  // two flop sync
  // select pull-down default
  // select/wake resets low to mimic the pin pull-down; the others idle high
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_ff <= 4'b1110;
      stage2_ff <= 4'b1110;
    end else begin
      stage1_ff <= {bus_level_in, tx_data_in, fault_enable_in, select_wake_in};
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out.select_wake = stage2_ff[0];
  assign sync_out.fault_enable = stage2_ff[1];
  assign sync_out.tx_data = stage2_ff[2];
  assign sync_out.bus_level = stage2_ff[3];
endmodule // lin_input_sync

// ---- core/lin_transceiver_mode_control.sv ----
// mode sequencer of a single-wire bus transceiver
`timescale 1ns/100ps
module lin_transceiver_mode_control #(
  parameter int WAKE_DEBOUNCE_CYCLES = lin_mode_pkg::WAKE_DEBOUNCE_CYCLES,
  parameter int MISMATCH_BLANK_CYCLES = lin_mode_pkg::MISMATCH_BLANK_CYCLES
) (
  input wire logic clk_in, // core clock, 100 MHz
  input wire logic rst_n_in, // async reset, active low
  input wire logic supply_above_on_in, // battery supply above turn-on threshold
  input wire logic supply_below_off_in, // battery supply below turn-off threshold
  input wire logic regulator_stable_in, // regulator output settled
  input wire logic regulator_good_in, // regulator above 0.8 of nominal
  input wire logic internal_fault_in, // thermal or driver fault present
  input wire logic select_wake_in, // host select / local wake pin
  input wire logic tx_data_in, // host transmit data pin
  input wire logic fault_enable_in, // fault/enable pin input level
  output logic fault_enable_out, // fault/enable pin drive value (always 0)
  output logic fault_enable_oe_out, // fault/enable pin pulls low when high
  input wire logic bus_level_in, // bus comparator level (normal or wake threshold)
  output logic bus_dominant_out, // drive bus dominant (open drain enable)
  output logic bus_pullup_out, // connect bus pull-up to battery
  output logic rx_data_out, // receive data to host
  output logic receiver_en_out, // receiver powered
  output logic transmitter_en_out, // transmitter powered
  output logic regulator_en_out, // regulator powered
  output logic regulator_low_power_out, // regulator in reduced-power operation
  output logic wake_threshold_sel_out, // bus comparator uses wake threshold
  output logic wake_detect_en_out, // bus wake detector active
  output logic reset_out, // reset to host, low while invalid
  output lin_mode_pkg::mode_t mode_out // current mode
);
  lin_sync_if sync_bus ();

  lin_mode_pkg::mode_t mode_ff;
  lin_mode_pkg::mode_t nxt_mode;
  logic select_prev_ff;
  logic enable_prev_ff;
  logic tx_prev_ff;
  logic [lin_mode_pkg::TIMER_W-1:0] wake_cnt_ff;
  logic wake_armed_ff;
  logic bus_wake;
  logic [lin_mode_pkg::TIMER_W-1:0] blank_cnt_ff;
  logic mismatch_fault_ff;
  logic tx_enabled;
  logic select_fall;
  logic enable_fall;

  // ------------------------------------------------------------
  // input synchronisation
  // ------------------------------------------------------------
  // sync all pins
  lin_input_sync u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .select_wake_in(select_wake_in),
    .fault_enable_in(fault_enable_in),
    .tx_data_in(tx_data_in),
    .bus_level_in(bus_level_in),
    .sync_out(sync_bus.producer)
  );

  // ------------------------------------------------------------
  // edge history
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      select_prev_ff <= 1'b0;
      enable_prev_ff <= 1'b1;
      tx_prev_ff <= 1'b1;
    end else begin
      select_prev_ff <= sync_bus.select_wake;
      enable_prev_ff <= sync_bus.fault_enable;
      tx_prev_ff <= sync_bus.tx_data;
    end
  end

  assign select_fall = select_prev_ff && !sync_bus.select_wake;
  assign enable_fall = enable_prev_ff && !sync_bus.fault_enable;

  // ------------------------------------------------------------
  // bus wake detector
  // ------------------------------------------------------------
  // debounced low then rise
  // the low-time counter saturates; a rise before the debounce time clears the count
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_cnt_ff <= '0;
      wake_armed_ff <= 1'b0;
    end else if (mode_ff != lin_mode_pkg::MODE_POWER_DOWN) begin
      wake_cnt_ff <= '0;
      wake_armed_ff <= 1'b0;
    end else if (!sync_bus.bus_level) begin
      if (32'(wake_cnt_ff) + 1 >= WAKE_DEBOUNCE_CYCLES) begin
        wake_armed_ff <= 1'b1;
      end else begin
        wake_cnt_ff <= wake_cnt_ff + 1'b1;
      end
    end else begin
      wake_cnt_ff <= '0;
      wake_armed_ff <= 1'b0;
    end
  end

  assign bus_wake = wake_armed_ff && sync_bus.bus_level;

  // ------------------------------------------------------------
  // transmit versus bus compare
  // ------------------------------------------------------------
  // blanked mismatch detect
  // a high select level gates the check; a falling tx edge restarts blanking
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      blank_cnt_ff <= '0;
      mismatch_fault_ff <= 1'b0;
    end else if (!sync_bus.select_wake || mode_ff != lin_mode_pkg::MODE_OPERATION) begin
      blank_cnt_ff <= '0;
      mismatch_fault_ff <= 1'b0;
    end else if (tx_prev_ff && !sync_bus.tx_data) begin
      blank_cnt_ff <= lin_mode_pkg::TIMER_W'(MISMATCH_BLANK_CYCLES);
      mismatch_fault_ff <= 1'b0;
    end else if (blank_cnt_ff != '0) begin
      blank_cnt_ff <= blank_cnt_ff - 1'b1;
    end else begin
      // only tx low against a recessive bus is a fault; tx high on a low bus is reception
      mismatch_fault_ff <= !sync_bus.tx_data && sync_bus.bus_level;
    end
  end

  // ------------------------------------------------------------
  // mode sequencing
  // ------------------------------------------------------------
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      lin_mode_pkg::MODE_POR: begin
        if (supply_above_on_in) begin
          nxt_mode = lin_mode_pkg::MODE_READY;
        end
      end
      lin_mode_pkg::MODE_READY: begin
        if (regulator_stable_in && sync_bus.select_wake) begin
          if (sync_bus.fault_enable && sync_bus.tx_data && regulator_good_in) begin
            nxt_mode = lin_mode_pkg::MODE_OPERATION;
          end else if (!sync_bus.fault_enable) begin
            nxt_mode = lin_mode_pkg::MODE_TX_OFF;
          end
        end
      end
      lin_mode_pkg::MODE_OPERATION: begin
        if (select_fall || !sync_bus.select_wake) begin
          nxt_mode = lin_mode_pkg::MODE_POWER_DOWN;
        end else if (enable_fall || !sync_bus.fault_enable || mismatch_fault_ff) begin
          nxt_mode = lin_mode_pkg::MODE_TX_OFF;
        end
      end
      lin_mode_pkg::MODE_TX_OFF: begin
        if (!sync_bus.select_wake) begin
          nxt_mode = lin_mode_pkg::MODE_POWER_DOWN;
        end else if (sync_bus.fault_enable && sync_bus.tx_data && regulator_good_in
                     && !internal_fault_in) begin
          nxt_mode = lin_mode_pkg::MODE_OPERATION;
        end
      end
      lin_mode_pkg::MODE_POWER_DOWN: begin
        if (bus_wake || sync_bus.select_wake) begin
          nxt_mode = lin_mode_pkg::MODE_READY;
        end
      end
      default: begin
        nxt_mode = lin_mode_pkg::MODE_POR;
      end
    endcase
    if (supply_below_off_in) begin
      nxt_mode = lin_mode_pkg::MODE_POR;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_ff <= lin_mode_pkg::MODE_POR;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // ------------------------------------------------------------
  // outputs decoded from next mode, registered
  // ------------------------------------------------------------
  // regulator gates tx
  assign tx_enabled = nxt_mode == lin_mode_pkg::MODE_OPERATION && regulator_good_in
                      && regulator_stable_in && !internal_fault_in;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_out <= lin_mode_pkg::MODE_POR;
      transmitter_en_out <= 1'b0;
      receiver_en_out <= 1'b0;
      regulator_en_out <= 1'b0;
      regulator_low_power_out <= 1'b0;
      bus_pullup_out <= 1'b0;
      wake_threshold_sel_out <= 1'b0;
      wake_detect_en_out <= 1'b0;
      reset_out <= lin_mode_pkg::RESET_LEVEL_RST;
    end else begin
      mode_out <= nxt_mode;
      transmitter_en_out <= tx_enabled;
      receiver_en_out <= nxt_mode inside {lin_mode_pkg::MODE_READY,
        lin_mode_pkg::MODE_OPERATION, lin_mode_pkg::MODE_TX_OFF};
      regulator_en_out <= nxt_mode inside {lin_mode_pkg::MODE_READY,
        lin_mode_pkg::MODE_OPERATION, lin_mode_pkg::MODE_TX_OFF};
      regulator_low_power_out <= nxt_mode inside {lin_mode_pkg::MODE_READY,
        lin_mode_pkg::MODE_TX_OFF};
      bus_pullup_out <= nxt_mode == lin_mode_pkg::MODE_OPERATION;
      wake_threshold_sel_out <= nxt_mode == lin_mode_pkg::MODE_POWER_DOWN;
      wake_detect_en_out <= nxt_mode == lin_mode_pkg::MODE_POWER_DOWN;
      reset_out <= nxt_mode != lin_mode_pkg::MODE_POR && regulator_good_in;
    end
  end

  // ------------------------------------------------------------
  // bus drive, receive path, fault pin
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_dominant_out <= 1'b0;
      rx_data_out <= 1'b1;
      fault_enable_out <= 1'b0;
      fault_enable_oe_out <= 1'b0;
    end else begin
      bus_dominant_out <= tx_enabled && !sync_bus.tx_data;
      rx_data_out <= sync_bus.bus_level;
      fault_enable_out <= 1'b0;
      fault_enable_oe_out <= sync_bus.select_wake
                             && (mismatch_fault_ff || internal_fault_in);
    end
  end
endmodule // lin_transceiver_mode_control

// ---- include/lin_mode_pkg.sv ----
// constants and types shared by the transceiver mode controller
package lin_mode_pkg;
  // mode encoding
  typedef enum logic [2:0] {
    MODE_POR,
    MODE_READY,
    MODE_OPERATION,
    MODE_TX_OFF,
    MODE_POWER_DOWN
  } mode_t;

  // clock rate
  localparam int CLK_PERIOD_NS = 10;
  // bus wake debounce, least time
  localparam int WAKE_DEBOUNCE_TIME_US = 80;
  localparam int WAKE_DEBOUNCE_CYCLES =
    (WAKE_DEBOUNCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // transmit/bus compare blanking after transmit falling edge
  localparam int MISMATCH_BLANK_TIME_US = 25;
  localparam int MISMATCH_BLANK_CYCLES =
    (MISMATCH_BLANK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // counter width covering both waits
  localparam int TIMER_W = 14;
  // reset value of the host reset output
  localparam logic RESET_LEVEL_RST = 1'b0;
endpackage

// ---- include/lin_sync_if.sv ----
// synchronised host pin and bus comparator levels passed from synchroniser to mode logic
`timescale 1ns/100ps
interface lin_sync_if;
  logic select_wake;
  logic fault_enable;
  logic tx_data;
  logic bus_level;

  modport producer (
    output select_wake,
    output fault_enable,
    output tx_data,
    output bus_level
  );
  modport consumer (
    input select_wake,
    input fault_enable,
    input tx_data,
    input bus_level
  );
endinterface

// ---- verif/lin_host_model.sv ----
// host controller model driving select, transmit and enable pins
`timescale 1ns/100ps
module lin_host_model (
  input wire logic clk_in, // clock
  output logic select_wake_out, // select / local wake
  output logic tx_data_out, // transmit data
  output logic enable_release_out // 1 releases enable pin, 0 pulls low
);
  // select held low until set up
  initial begin
    select_wake_out = 1'b0;
    tx_data_out = 1'b1;
    enable_release_out = 1'b1;
  end
  // enable only released, never forced high
  task automatic drive(input logic s, input logic e, input logic t);
    @(negedge clk_in);
    select_wake_out = s;
    enable_release_out = e;
    tx_data_out = t;
  endtask
endmodule // lin_host_model

// ---- verif/lin_mode_control_sva.sv ----
// port assertions for the transceiver mode controller
`timescale 1ns/100ps
module lin_mode_control_sva (
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic supply_below_off_in, // supply low
  input wire logic regulator_stable_in, // reg settled
  input wire logic regulator_good_in, // reg good
  input wire logic internal_fault_in, // fault
  input wire logic select_wake_in, // select
  input wire logic tx_data_in, // tx data
  input wire logic bus_level_in, // bus level
  input wire logic bus_dominant_out, // bus drive
  input wire logic bus_pullup_out, // pull-up
  input wire logic rx_data_out, // rx data
  input wire logic receiver_en_out, // receiver
  input wire logic transmitter_en_out, // transmitter
  input wire logic regulator_en_out, // regulator
  input wire logic regulator_low_power_out, // reduced power
  input wire logic wake_threshold_sel_out, // wake threshold
  input wire logic wake_detect_en_out, // wake detector
  input wire logic reset_out, // host reset
  input wire lin_mode_pkg::mode_t mode_out // mode
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic m_por, m_rdy, m_op, m_off, m_pd;
  assign m_por = mode_out == lin_mode_pkg::MODE_POR;
  assign m_rdy = mode_out == lin_mode_pkg::MODE_READY;
  assign m_op = mode_out == lin_mode_pkg::MODE_OPERATION;
  assign m_off = mode_out == lin_mode_pkg::MODE_TX_OFF;
  assign m_pd = mode_out == lin_mode_pkg::MODE_POWER_DOWN;
  property p_por_entry; supply_below_off_in |=> m_por; endproperty
  a_por_entry: assert property (p_por_entry)
    else $error("low supply did not reset");
  property p_por_outs; m_por |-> !regulator_en_out && !receiver_en_out && !reset_out; endproperty
  a_por_outs: assert property (p_por_outs)
    else $error("reset mode outputs wrong");
  property p_ready_outs; m_rdy |-> regulator_en_out && regulator_low_power_out
    && receiver_en_out && !transmitter_en_out; endproperty
  a_ready_outs: assert property (p_ready_outs)
    else $error("ready outputs wrong");
  property p_ready_wait; m_rdy && !regulator_stable_in |=> m_rdy || m_por; endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("left ready while regulator unsettled");
  property p_pullup; bus_pullup_out == m_op; endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up outside operation");
  property p_txoff_outs; m_off |-> receiver_en_out && !transmitter_en_out
    && regulator_low_power_out; endproperty
  a_txoff_outs: assert property (p_txoff_outs)
    else $error("tx-off outputs wrong");
  property p_tx_block; internal_fault_in || !regulator_good_in || !regulator_stable_in
    |=> !transmitter_en_out; endproperty
  a_tx_block: assert property (p_tx_block)
    else $error("transmitter on during fault");
  property p_pd_outs; m_pd |-> wake_detect_en_out && wake_threshold_sel_out
    && !regulator_en_out && !receiver_en_out && !transmitter_en_out; endproperty
  a_pd_outs: assert property (p_pd_outs)
    else $error("power-down outputs wrong");
  property p_sel_group; !select_wake_in [*4] |-> m_por || m_rdy || m_pd; endproperty
  a_sel_group: assert property (p_sel_group)
    else $error("active mode with select low");
  property p_rx; rx_data_out == $past(bus_level_in, 3); endproperty
  a_rx: assert property (p_rx)
    else $error("rx does not follow bus");
  property p_dom; transmitter_en_out |-> bus_dominant_out == !$past(tx_data_in, 3); endproperty
  a_dom: assert property (p_dom)
    else $error("bus drive differs from tx data");
  c_op: cover property (m_op);
  c_off: cover property (m_off);
  c_wake: cover property (m_pd ##1 m_rdy);
endmodule // lin_mode_control_sva

// ---- verif/tb.sv ----
// self-checking bench for the transceiver mode controller
`timescale 1ns/100ps
module tb;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic on = 1'b0, off = 1'b0, stab = 1'b0, good = 1'b0, flt = 1'b0, bus = 1'b1;
  logic sel, txd, enr, fe, oe, dom, pu, rx, rxe, txe, rge, rlp, wts, wde, rso;
  // bus held recessive by a short to battery
  logic sht = 1'b0;
  lin_mode_pkg::mode_t mode;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  lin_host_model host (.clk_in(clk_in), .select_wake_out(sel), .tx_data_out(txd),
    .enable_release_out(enr));
  lin_transceiver_mode_control #(.WAKE_DEBOUNCE_CYCLES(20), .MISMATCH_BLANK_CYCLES(10)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .supply_above_on_in(on),
    .supply_below_off_in(off), .regulator_stable_in(stab), .regulator_good_in(good),
    .internal_fault_in(flt), .select_wake_in(sel), .tx_data_in(txd),
    .fault_enable_in(enr & ~oe), .fault_enable_out(fe), .fault_enable_oe_out(oe),
    .bus_level_in((bus & ~dom) | sht), .bus_dominant_out(dom), .bus_pullup_out(pu),
    .rx_data_out(rx), .receiver_en_out(rxe), .transmitter_en_out(txe),
    .regulator_en_out(rge), .regulator_low_power_out(rlp), .wake_threshold_sel_out(wts),
    .wake_detect_en_out(wde), .reset_out(rso), .mode_out(mode));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  // ----------------------------------------
  // shared checks
  // ----------------------------------------
  task automatic chk(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  // polls after each edge so the edge's updates have landed
  task automatic go(input lin_mode_pkg::mode_t m, input int lim, input string what);
    int i;
    i = 0;
    while (mode !== m && i < lim) begin
      @(posedge clk_in);
      #1;
      i++;
    end
    chk(mode === m, 1'b1, what);
  endtask
  task automatic stay(input lin_mode_pkg::mode_t m, input int n, input string what);
    repeat (n) begin
      @(posedge clk_in);
      #1;
      chk(mode === m, 1'b1, what);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_power_up();
    stay(lin_mode_pkg::MODE_POR, 3, "left reset early");
    chk(rso, 1'b0, "host reset high");
    @(negedge clk_in);
    on = 1'b1;
    go(lin_mode_pkg::MODE_READY, 3, "no ready");
    chk(rge & rlp & rxe & ~txe, 1'b1, "ready outputs");
    host.drive(1'b1, 1'b1, 1'b0);
    stay(lin_mode_pkg::MODE_READY, 6, "left ready unsettled");
    @(negedge clk_in);
    stab = 1'b1;
    good = 1'b1;
    stay(lin_mode_pkg::MODE_READY, 6, "operation with tx low");
    host.drive(1'b1, 1'b1, 1'b1);
    go(lin_mode_pkg::MODE_OPERATION, 4, "no operation");
    chk(pu & txe & ~rlp, 1'b1, "operation outputs");
  endtask
  task automatic s_transmit();
    @(negedge clk_in);
    bus = 1'b0;
    stay(lin_mode_pkg::MODE_OPERATION, 16, "reception taken as fault");
    chk(rx, 1'b0, "rx not low on received data");
    @(negedge clk_in);
    bus = 1'b1;
    host.drive(1'b1, 1'b1, 1'b0);
    repeat (6) @(posedge clk_in);
    #1;
    chk(dom, 1'b1, "no dominant");
    chk(rx, 1'b0, "rx not low");
    @(negedge clk_in);
    sht = 1'b1;
    go(lin_mode_pkg::MODE_TX_OFF, 20, "mismatch missed");
    chk(oe, 1'b1, "enable pin not pulled");
    chk(fe, 1'b0, "enable pin drive value not low");
    host.drive(1'b1, 1'b1, 1'b1);
    sht = 1'b0;
    go(lin_mode_pkg::MODE_OPERATION, 12, "no return");
  endtask
  task automatic s_tx_off();
    host.drive(1'b1, 1'b0, 1'b1);
    go(lin_mode_pkg::MODE_TX_OFF, 4, "no tx-off");
    chk(rxe & ~txe & rlp, 1'b1, "tx-off outputs");
    @(negedge clk_in);
    flt = 1'b1;
    host.drive(1'b1, 1'b1, 1'b1);
    stay(lin_mode_pkg::MODE_TX_OFF, 6, "fault ignored");
    chk(oe, 1'b1, "fault not on enable pin");
    @(negedge clk_in);
    flt = 1'b0;
    go(lin_mode_pkg::MODE_OPERATION, 5, "no re-enable");
    @(negedge clk_in);
    good = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk(txe, 1'b0, "tx on, regulator bad");
    @(negedge clk_in);
    good = 1'b1;
  endtask
  task automatic s_sleep();
    host.drive(1'b0, 1'b1, 1'b1);
    go(lin_mode_pkg::MODE_POWER_DOWN, 4, "no power-down");
    chk(wde & wts & ~rge & ~rxe, 1'b1, "power-down outputs");
    host.drive(1'b1, 1'b1, 1'b1);
    go(lin_mode_pkg::MODE_READY, 4, "no local wake");
    go(lin_mode_pkg::MODE_OPERATION, 4, "no operation");
    host.drive(1'b0, 1'b1, 1'b1);
    go(lin_mode_pkg::MODE_POWER_DOWN, 4, "no power-down");
    @(negedge clk_in);
    bus = 1'b0;
    repeat (8) @(negedge clk_in);
    bus = 1'b1;
    stay(lin_mode_pkg::MODE_POWER_DOWN, 8, "short pulse woke");
    @(negedge clk_in);
    bus = 1'b0;
    stay(lin_mode_pkg::MODE_POWER_DOWN, 30, "woke before rise");
    @(negedge clk_in);
    bus = 1'b1;
    go(lin_mode_pkg::MODE_READY, 5, "no bus wake");
    stay(lin_mode_pkg::MODE_READY, 4, "active with select low");
  endtask
  task automatic s_supply_drop();
    @(negedge clk_in);
    off = 1'b1;
    go(lin_mode_pkg::MODE_POR, 2, "no reset mode");
    chk(rge | rxe | rso, 1'b0, "reset mode outputs");
    @(negedge clk_in);
    off = 1'b0;
    go(lin_mode_pkg::MODE_READY, 3, "no ready");
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      $display("[ERR] %0t timeout", $time);
      complete_run();
    end
  end
  initial begin
    repeat (16) @(negedge clk_in);
    rst_n_in = 1'b1;
    s_power_up();
    s_transmit();
    s_tx_off();
    s_sleep();
    s_supply_drop();
    complete_run();
  end
endmodule // tb
bind lin_transceiver_mode_control lin_mode_control_sva chk (.*);
